// ---- core/pcr_cfg.svh ----
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

// Dword indices of the capability registers in configuration space.
`define PCR_IDX_PBA      6'h1a
`define PCR_IDX_PCIX     6'h1b
`define PCR_IDX_STAT     6'h1c

// Locator fields.
`define PCR_BIR_HI       2
`define PCR_BIR_LO       0
`define PCR_BAR_FIRST    8'h10
`define PCR_BIR_LAST     3'h5

// Capability identifier dword: id, next pointer, command.
`define PCR_CAP_ID       8'h07
`define PCR_CMD_DPR_BIT  0
`define PCR_CMD_MRBC_HI  3
`define PCR_CMD_MRBC_LO  2
`define PCR_CMD_MOST_HI  6
`define PCR_CMD_MOST_LO  4
`define PCR_CMD_MOST_RST 3'h6
`define PCR_CMD_MRBC_RST 2'h0
`define PCR_CMD_DPR_RST  1'h0

// Status fields.
`define PCR_ST_RSCE_BIT  29
`define PCR_ST_DMCRS     3'h4
`define PCR_ST_DMOST     3'h6
`define PCR_ST_DMMRBC    2'h2
`define PCR_ST_CPLX      1'h0
`define PCR_ST_USC_BIT   19
`define PCR_ST_SCD_BIT   18

// Edges after reset release before the sense pins are caught.
`define PCR_STRAP_WAIT   2'h3

`endif

// ---- core/pcr_pkg.sv ----
package pcr_pkg;

	typedef logic [4:0]  pcr_split_cnt_t;
	typedef logic [11:0] pcr_byte_cnt_t;

	// Reserved code 3'h7 falls back to the smallest limit.
	function automatic pcr_split_cnt_t pcr_most_limit(input logic [2:0] code);
		unique case (code)
			3'h0: pcr_most_limit = 5'h01;
			3'h1: pcr_most_limit = 5'h02;
			3'h2: pcr_most_limit = 5'h03;
			3'h3: pcr_most_limit = 5'h04;
			3'h4: pcr_most_limit = 5'h08;
			3'h5: pcr_most_limit = 5'h0c;
			3'h6: pcr_most_limit = 5'h10;
			3'h7: pcr_most_limit = 5'h01;
		endcase
	endfunction : pcr_most_limit

	// Reserved code 2'h3 falls back to the smallest byte count.
	function automatic pcr_byte_cnt_t pcr_mrbc_bytes(input logic [1:0] code);
		unique case (code)
			2'h0: pcr_mrbc_bytes = 12'h200;
			2'h1: pcr_mrbc_bytes = 12'h400;
			2'h2: pcr_mrbc_bytes = 12'h800;
			2'h3: pcr_mrbc_bytes = 12'h200;
		endcase
	endfunction : pcr_mrbc_bytes

endpackage : pcr_pkg

// ---- core/pcr_seq_limit.sv ----
`timescale 1ns/100ps
`default_nettype none

module pcr_seq_limit #(
	parameter int MAX_SPLITS = 16
) (
	// Clock and reset
	input  wire logic                   mclk_in,
	input  wire logic                   rstn_in,
	// Live command fields
	input  wire logic [2:0]             most_code_in,
	input  wire logic [1:0]             mrbc_code_in,
	// Sequence events
	input  wire logic                   seq_prep_in,
	input  wire logic                   split_issue_in,
	input  wire logic                   split_done_in,
	// Limits of the prepared sequence
	output var pcr_pkg::pcr_split_cnt_t seq_limit_out,
	output var pcr_pkg::pcr_byte_cnt_t  seq_bytes_out,
	output logic                        split_room_out,
	output var pcr_pkg::pcr_split_cnt_t outstanding_out
);
	import pcr_pkg::*;

	initial begin
		if (MAX_SPLITS != 16)
			$error("pcr_seq_limit: the limit table tops out at sixteen");
	end

	pcr_split_cnt_t cnt_d;
	pcr_split_cnt_t lim_d;
	logic           inc;
	logic           dec;

	// Limits are caught only when a sequence is prepared, so a later
	// command write does not disturb a sequence already prepared.
	assign lim_d = seq_prep_in ? pcr_most_limit(most_code_in) : seq_limit_out;
	assign inc   = split_issue_in && split_room_out;
	assign dec   = split_done_in && (outstanding_out != 5'h00);
	assign cnt_d = outstanding_out + 5'(inc) - 5'(dec);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			seq_limit_out   <= 5'h01;
			seq_bytes_out   <= 12'h200;
			outstanding_out <= 5'h00;
			split_room_out  <= 1'b1;
		end else begin
			seq_limit_out   <= lim_d;
			if (seq_prep_in)
				seq_bytes_out <= pcr_mrbc_bytes(mrbc_code_in);
			outstanding_out <= cnt_d;
			split_room_out  <= cnt_d < lim_d;
		end
	end

endmodule : pcr_seq_limit

`default_nettype wire

// ---- core/pcr_regs.sv ----
`include "pcr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module pcr_regs #(
	parameter logic [31:0] PBA_OFFSET = 32'h0000_2000,
	parameter logic [2:0]  PBA_BIR    = 3'h0,
	parameter int          MAX_SPLITS = 16
) (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	// Configuration access, type 0, addressed to this function
	input  wire logic        cfg_req_in,
	input  wire logic        cfg_we_in,
	input  wire logic [5:0]  cfg_idx_in,
	input  wire logic [3:0]  cfg_be_in,
	input  wire logic [31:0] cfg_wdata_in,
	input  wire logic [2:0]  cfg_fn_in,
	output logic             cfg_ack_out,
	output logic [31:0]      cfg_rdata_out,
	// Identity and list position from the bus interface
	input  wire logic [7:0]  bus_num_in,
	input  wire logic [4:0]  dev_num_in,
	input  wire logic [7:0]  next_ptr_in,
	// Power-on sense pins: bit 1 gates 133 MHz, bit 0 the 64-bit bus
	input  wire logic [1:0]  power_on_sense_pins_in,
	// Completion and parity events
	input  wire logic        cmpl_err_msg_in,
	input  wire logic        unexp_cmpl_in,
	input  wire logic        cmpl_drop_in,
	input  wire logic        pcix_mode_in,
	input  wire logic        mdpe_status_in,
	output logic             serr_req_out,
	// Sequence engine
	input  wire logic        seq_prep_in,
	input  wire logic        split_issue_in,
	input  wire logic        split_done_in,
	output var pcr_pkg::pcr_split_cnt_t seq_limit_out,
	output var pcr_pkg::pcr_byte_cnt_t  seq_bytes_out,
	output logic             split_room_out,
	// Fixed, strapped and identity facts for the rest of the device
	output logic [7:0]       pba_bar_addr_out,
	output logic             allow_133_out,
	output logic             bus_64_out,
	output logic [15:0]      requester_id_out
);
	import pcr_pkg::*;

	initial begin
		if (PBA_BIR > `PCR_BIR_LAST)
			$error("pcr_regs: base register indicator 6 and 7 are reserved");
	end

	// Command register.
	logic [2:0] most_q;
	logic [1:0] mrbc_q;
	logic       dpr_q;

	// Status register.
	logic       rsce_q;
	logic       usc_q;
	logic       scd_q;
	logic       cap133_q;
	logic       bus64_q;
	logic [7:0] bus_q;
	logic [4:0] dev_q;
	logic [2:0] fn_q;

	// Strap capture.
	logic [1:0] sense_s1_q;
	logic [1:0] sense_s2_q;
	logic [1:0] strap_cnt_q;
	logic       strap_done_q;

	// Parity watch.
	logic       mdpe_prev_q;

	// Access decode.
	wire        hit_pba  = cfg_idx_in == `PCR_IDX_PBA;
	wire        hit_pcix = cfg_idx_in == `PCR_IDX_PCIX;
	wire        hit_stat = cfg_idx_in == `PCR_IDX_STAT;
	wire        wr       = cfg_req_in && cfg_we_in;
	wire        wr_cmd   = wr && hit_pcix && cfg_be_in[2];
	wire        wr_st_hi = wr && hit_stat && cfg_be_in[3];
	wire        wr_st_md = wr && hit_stat && cfg_be_in[2];

	// Write-one-to-clear terms; a hardware set in the same cycle wins.
	wire        clr_rsce = wr_st_hi && cfg_wdata_in[`PCR_ST_RSCE_BIT];
	wire        clr_usc  = wr_st_md && cfg_wdata_in[`PCR_ST_USC_BIT];
	wire        clr_scd  = wr_st_md && cfg_wdata_in[`PCR_ST_SCD_BIT];
	wire        rsce_d   = cmpl_err_msg_in || (rsce_q && !clr_rsce);
	wire        usc_d    = unexp_cmpl_in || (usc_q && !clr_usc);
	wire        scd_d    = cmpl_drop_in || (scd_q && !clr_scd);

	// Read images.
	wire [31:0] pba_word = {PBA_OFFSET[31:3], PBA_BIR};
	wire [15:0] cmd_word = {9'h000, most_q, mrbc_q, 1'b0, dpr_q};
	wire [31:0] pcix_word = {cmd_word, next_ptr_in, `PCR_CAP_ID};
	wire [31:0] stat_word = {
		2'h0,
		rsce_q,
		`PCR_ST_DMCRS,
		`PCR_ST_DMOST,
		`PCR_ST_DMMRBC,
		`PCR_ST_CPLX,
		usc_q,
		scd_q,
		cap133_q,
		bus64_q,
		bus_q,
		dev_q,
		fn_q
	};
	wire [31:0] rd_mux = hit_pba  ? pba_word  :
	                     hit_pcix ? pcix_word :
	                     hit_stat ? stat_word : 32'h0000_0000;

	// Base register picked by the locator indicator.
	wire [7:0]  bar_addr = `PCR_BAR_FIRST + {3'h0, PBA_BIR, 2'h0};

	// Parity error reporting when recovery is off.
	wire        mdpe_rise = mdpe_status_in && !mdpe_prev_q;
	wire        serr_d    = mdpe_rise && pcix_mode_in && !dpr_q;

	// Straps sit on pins, so they pass two flops before use.
	wire        strap_take = !strap_done_q && (strap_cnt_q == `PCR_STRAP_WAIT);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_ack_out   <= 1'b0;
			cfg_rdata_out <= 32'h0000_0000;
		end else begin
			cfg_ack_out   <= cfg_req_in;
			cfg_rdata_out <= (cfg_req_in && !cfg_we_in) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			most_q <= `PCR_CMD_MOST_RST;
			mrbc_q <= `PCR_CMD_MRBC_RST;
			dpr_q  <= `PCR_CMD_DPR_RST;
		end else if (wr_cmd) begin
			most_q <= cfg_wdata_in[16 + `PCR_CMD_MOST_HI:16 + `PCR_CMD_MOST_LO];
			mrbc_q <= cfg_wdata_in[16 + `PCR_CMD_MRBC_HI:16 + `PCR_CMD_MRBC_LO];
			dpr_q  <= cfg_wdata_in[16 + `PCR_CMD_DPR_BIT];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rsce_q <= 1'b0;
			usc_q  <= 1'b0;
			scd_q  <= 1'b0;
		end else begin
			rsce_q <= rsce_d;
			usc_q  <= usc_d;
			scd_q  <= scd_d;
		end
	end

	// Function number follows each type 0 access; bus and device numbers
	// track the bus interface so the identifiers never go stale.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_q <= 8'h00;
			dev_q <= 5'h00;
			fn_q  <= 3'h0;
		end else begin
			bus_q <= bus_num_in;
			dev_q <= dev_num_in;
			if (cfg_req_in)
				fn_q <= cfg_fn_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sense_s1_q <= 2'h0;
			sense_s2_q <= 2'h0;
		end else begin
			sense_s1_q <= power_on_sense_pins_in;
			sense_s2_q <= sense_s1_q;
		end
	end

	// The straps are caught once, after the synchroniser has filled, and
	// then held; later pin activity cannot change the reported bus type.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			strap_cnt_q  <= 2'h0;
			strap_done_q <= 1'b0;
			cap133_q     <= 1'b0;
			bus64_q      <= 1'b0;
		end else begin
			if (!strap_done_q && !strap_take)
				strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_take) begin
				strap_done_q <= 1'b1;
				cap133_q     <= !sense_s2_q[1];
				bus64_q      <= !sense_s2_q[0];
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mdpe_prev_q  <= 1'b0;
			serr_req_out <= 1'b0;
		end else begin
			mdpe_prev_q  <= mdpe_status_in;
			serr_req_out <= serr_d;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pba_bar_addr_out <= 8'h00;
			allow_133_out    <= 1'b0;
			bus_64_out       <= 1'b0;
			requester_id_out <= 16'h0000;
		end else begin
			pba_bar_addr_out <= bar_addr;
			allow_133_out    <= cap133_q;
			bus_64_out       <= bus64_q;
			requester_id_out <= {bus_q, dev_q, fn_q};
		end
	end

	// Sequences take their limits from the command register at preparation.
	pcr_seq_limit #(
		.MAX_SPLITS (MAX_SPLITS)
	) u_seq_limit (
		.mclk_in         (mclk_in),
		.rstn_in         (rstn_in),
		.most_code_in    (most_q),
		.mrbc_code_in    (mrbc_q),
		.seq_prep_in     (seq_prep_in),
		.split_issue_in  (split_issue_in),
		.split_done_in   (split_done_in),
		.seq_limit_out   (seq_limit_out),
		.seq_bytes_out   (seq_bytes_out),
		.split_room_out  (split_room_out),
		.outstanding_out ()
	);

endmodule : pcr_regs

`default_nettype wire

// ---- tb/pcr_regs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

module pcr_regs_monitor #(
	parameter logic [31:0] PBA_OFFSET = 32'h0000_2000,
	parameter logic [2:0]  PBA_BIR    = 3'h0,
	parameter int          MAX_SPLITS = 16
) (
	// Clock and reset
	input wire logic        mclk_in,
	input wire logic        rstn_in,
	// Configuration access
	input wire logic        cfg_req_in,
	input wire logic        cfg_we_in,
	input wire logic [5:0]  cfg_idx_in,
	input wire logic [31:0] cfg_rdata_out,
	// Identity and events
	input wire logic [7:0]  bus_num_in,
	input wire logic [4:0]  dev_num_in,
	input wire logic [7:0]  next_ptr_in,
	input wire logic        pcix_mode_in,
	input wire logic        mdpe_status_in,
	input wire logic        serr_req_out,
	input wire logic [7:0]  pba_bar_addr_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	wire rd    = cfg_req_in && !cfg_we_in;
	wire rd_pa = rd && cfg_idx_in == 6'h1a;
	wire rd_id = rd && cfg_idx_in == 6'h1b;
	wire rd_st = rd && cfg_idx_in == 6'h1c;
	wire rd_un = rd && !rd_pa && !rd_id && !rd_st;

	a_pba_locator: assert property (rd_pa |=> cfg_rdata_out == {PBA_OFFSET[31:3], PBA_BIR})
		else $error("locator read wrong");
	a_bar_select: assert property ($past(rstn_in) |-> pba_bar_addr_out == 8'h10 + {3'h0, PBA_BIR, 2'b00})
		else $error("base register address wrong");
	a_id_next: assert property (rd_id |=> cfg_rdata_out[15:0] == {$past(next_ptr_in), 8'h07})
		else $error("identifier or next pointer wrong");
	a_stat_fixed: assert property (rd_st |=> cfg_rdata_out[31:30] == 2'b00 && cfg_rdata_out[28:20] == {3'h4, 3'h6, 2'h2, 1'b0})
		else $error("fixed status fields wrong");
	a_stat_ident: assert property (rd_st && $stable(bus_num_in) && $stable(dev_num_in) |=> cfg_rdata_out[15:3] == $past({bus_num_in, dev_num_in}))
		else $error("bus or device number wrong");
	a_unmapped_zero: assert property (rd_un |=> cfg_rdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_serr_cause: assert property (serr_req_out |-> $past(mdpe_status_in) && !$past(mdpe_status_in, 2) && $past(pcix_mode_in))
		else $error("error signal without parity rise");
	a_serr_pulse: assert property (serr_req_out |=> !serr_req_out)
		else $error("error signal longer than one cycle");

	c_serr: cover property (serr_req_out);
	c_stat: cover property (rd_st);
	c_unmapped: cover property (rd_un);
endmodule : pcr_regs_monitor

bind pcr_regs pcr_regs_monitor #(.PBA_OFFSET(PBA_OFFSET), .PBA_BIR(PBA_BIR), .MAX_SPLITS(MAX_SPLITS)) u_pcr_regs_monitor (
	.mclk_in(mclk_in), .rstn_in(rstn_in), .cfg_req_in(cfg_req_in), .cfg_we_in(cfg_we_in),
	.cfg_idx_in(cfg_idx_in), .cfg_rdata_out(cfg_rdata_out), .bus_num_in(bus_num_in),
	.dev_num_in(dev_num_in), .next_ptr_in(next_ptr_in), .pcix_mode_in(pcix_mode_in),
	.mdpe_status_in(mdpe_status_in), .serr_req_out(serr_req_out), .pba_bar_addr_out(pba_bar_addr_out)
);

`default_nettype wire

// ---- tb/pcr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module pcr_host_model #(
	parameter logic [2:0] FN = 3'h0
) (
	// Clock
	input  wire logic        mclk_in,
	// Type 0 configuration access
	output logic             req_out,
	output logic             we_out,
	output logic [5:0]       idx_out,
	output logic [3:0]       be_out,
	output logic [31:0]      wdata_out,
	output logic [2:0]       fn_out,
	input  wire logic        ack_in,
	input  wire logic [31:0] rdata_in
);
	initial begin
		{req_out, we_out, idx_out, be_out, wdata_out} = '0;
		fn_out = FN;
	end

	// The function takes the request at one edge, so it stands for exactly that edge.
	task automatic access(input logic w, input logic [5:0] i, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk_in);
		req_out   <= 1'b1;
		we_out    <= w;
		idx_out   <= i;
		be_out    <= b;
		wdata_out <= d;
		@(posedge mclk_in);
		req_out   <= 1'b0;
		// A released bus never shows the old data.
		wdata_out <= ~d;
		#1 r = ack_in ? rdata_in : 32'hxxxx_xxxx;
	endtask : access
endmodule : pcr_host_model

`default_nettype wire

// ---- tb/pcix_capability_registers_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module pcix_capability_registers_tb;
	import pcr_pkg::*;
	logic           mclk_in;
	logic           rstn_in = 1'b0;
	logic           req, we, ack, serr, room, a133, b64;
	logic [5:0]     idx;
	logic [3:0]     be;
	logic [31:0]    wd, rdata, rdv;
	logic [2:0]     fn;
	logic [1:0]     pins = 2'b01;
	logic [2:0]     ev = 3'h0;
	logic           pcix = 1'b0;
	logic           mdpe = 1'b0;
	logic           prep = 1'b0;
	logic           iss = 1'b0;
	logic           dn = 1'b0;
	logic [7:0]     busn = 8'h3c;
	pcr_split_cnt_t lim_o;
	pcr_byte_cnt_t  byt_o;
	logic [7:0]     bar;
	logic [15:0]    rid;
	int             errors, n_checks, cyc, ns;
	logic [4:0]     lim [7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h0c, 5'h10};
	logic [11:0]    byt [3] = '{12'h200, 12'h400, 12'h800};

	pcr_host_model #(.FN(3'h5)) u_pcr_host_model (.mclk_in(mclk_in), .req_out(req), .we_out(we),
		.idx_out(idx), .be_out(be), .wdata_out(wd), .fn_out(fn), .ack_in(ack), .rdata_in(rdata));

	pcr_regs #(.PBA_OFFSET(32'h0001_2340), .PBA_BIR(3'h5)) u_pcr_regs (.mclk_in(mclk_in),
		.rstn_in(rstn_in), .cfg_req_in(req), .cfg_we_in(we), .cfg_idx_in(idx), .cfg_be_in(be),
		.cfg_wdata_in(wd), .cfg_fn_in(fn), .cfg_ack_out(ack), .cfg_rdata_out(rdata),
		.bus_num_in(busn), .dev_num_in(5'h0b), .next_ptr_in(8'h38),
		.power_on_sense_pins_in(pins), .cmpl_err_msg_in(ev[2]), .unexp_cmpl_in(ev[1]),
		.cmpl_drop_in(ev[0]), .pcix_mode_in(pcix), .mdpe_status_in(mdpe), .serr_req_out(serr),
		.seq_prep_in(prep), .split_issue_in(iss), .split_done_in(dn), .seq_limit_out(lim_o),
		.seq_bytes_out(byt_o), .split_room_out(room), .pba_bar_addr_out(bar),
		.allow_133_out(a133), .bus_64_out(b64), .requester_id_out(rid));

	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	// Cycle budget is about 130; the ceiling only catches a hang.
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cfg(input logic w, input logic [5:0] i, input logic [3:0] b, input logic [31:0] d);
		u_pcr_host_model.access(w, i, b, d, rdv);
	endtask : cfg

	task automatic t_fixed();
		cfg(1'b0, 6'h1a, 4'hf, 32'h0);
		chk(rdv, 32'h0001_2345);
		cfg(1'b1, 6'h1a, 4'hf, 32'hffff_ffff);
		cfg(1'b0, 6'h1a, 4'hf, 32'h0);
		chk(rdv, 32'h0001_2345);
		chk({24'h0, bar}, 32'h24);
		cfg(1'b0, 6'h1b, 4'hf, 32'h0);
		chk(rdv, 32'h0060_3807);
		cfg(1'b0, 6'h1c, 4'hf, 32'h0);
		chk(rdv, 32'h1342_3c5d);
		chk({16'h0, rid}, 32'h3c5d);
		chk({30'h0, a133, b64}, 32'h2);
		cfg(1'b0, 6'h00, 4'hf, 32'h0);
		chk(rdv, 32'h0);
		$display("t_fixed done");
	endtask : t_fixed

	task automatic t_cmd();
		cfg(1'b1, 6'h1b, 4'hf, 32'hffff_ffff);
		cfg(1'b1, 6'h1b, 4'hb, 32'h0);
		cfg(1'b0, 6'h1b, 4'hf, 32'h0);
		chk(rdv, 32'h007d_3807);
		for (int c = 0; c < 7; c++) begin
			cfg(1'b1, 6'h1b, 4'h4, {9'h0, 3'(c), 2'(c % 3), 2'b00, 16'h0});
			if (c > 0) chk({27'h0, lim_o}, {27'h0, lim[c-1]});
			@(posedge mclk_in);
			prep <= 1'b1;
			@(posedge mclk_in);
			prep <= 1'b0;
			#1 chk({27'h0, lim_o}, {27'h0, lim[c]});
			chk({20'h0, byt_o}, {20'h0, byt[c % 3]});
		end
		$display("t_cmd done");
	endtask : t_cmd

	task automatic t_flags();
		@(posedge mclk_in);
		ev <= 3'h7;
		@(posedge mclk_in);
		ev <= 3'h0;
		cfg(1'b0, 6'h1c, 4'hf, 32'h0);
		chk(rdv & 32'h200c_0000, 32'h200c_0000);
		cfg(1'b1, 6'h1c, 4'h3, 32'hffff_ffff);
		cfg(1'b0, 6'h1c, 4'hf, 32'h0);
		chk(rdv & 32'h200c_0000, 32'h200c_0000);
		cfg(1'b1, 6'h1c, 4'hc, 32'h200c_0000);
		cfg(1'b0, 6'h1c, 4'hf, 32'h0);
		chk(rdv & 32'h200c_0000, 32'h0);
		$display("t_flags done");
	endtask : t_flags

	// Limit of one split: a second issue must find no room until one completes.
	task automatic t_split();
		cfg(1'b1, 6'h1b, 4'h4, 32'h0);
		@(posedge mclk_in);
		prep <= 1'b1;
		@(posedge mclk_in);
		prep <= 1'b0;
		#1 chk({31'h0, room}, 32'h1);
		@(posedge mclk_in);
		iss <= 1'b1;
		@(posedge mclk_in);
		iss <= 1'b0;
		#1 chk({31'h0, room}, 32'h0);
		@(posedge mclk_in);
		iss <= 1'b1;
		@(posedge mclk_in);
		iss <= 1'b0;
		#1 chk({31'h0, room}, 32'h0);
		@(posedge mclk_in);
		dn <= 1'b1;
		@(posedge mclk_in);
		dn <= 1'b0;
		#1 chk({31'h0, room}, 32'h1);
		@(posedge mclk_in);
		busn <= 8'h5a;
		cfg(1'b0, 6'h1c, 4'hf, 32'h0);
		chk({24'h0, rdv[15:8]}, 32'h5a);
		$display("t_split done");
	endtask : t_split

	task automatic sc(input logic m, input logic dp, input int expn);
		cfg(1'b1, 6'h1b, 4'h4, {15'h0, dp, 16'h0});
		@(posedge mclk_in);
		pcix <= m;
		@(posedge mclk_in);
		mdpe <= 1'b1;
		ns = 0;
		repeat (6) begin
			@(posedge mclk_in);
			#1 if (serr === 1'b1) ns++;
		end
		@(posedge mclk_in);
		mdpe <= 1'b0;
		chk(ns, expn);
	endtask : sc

	initial begin
		repeat (16) @(posedge mclk_in);
		rstn_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		t_fixed();
		t_cmd();
		t_flags();
		t_split();
		sc(1'b1, 1'b0, 1);
		sc(1'b0, 1'b0, 0);
		sc(1'b1, 1'b1, 0);
		$display("t_serr done");
		complete_run();
	end
endmodule : pcix_capability_registers_tb

`default_nettype wire
